// [hdl/dlo_ddr_out.sv]
// Sample FIFO and DDR differential output stage with its register slave
`timescale 1ns/1ns

module dlo_fifo
#(
	parameter int WIDTH = 12,
	parameter int DEPTH = 16,
	localparam int AW   = $clog2(DEPTH),
	localparam int CW   = $clog2(DEPTH + 1)
)
(
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             rst,
	// Filling side
	input  wire logic             in_valid,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  in_ready,
	// Draining side
	output logic                  out_valid,
	output logic [WIDTH-1:0]      out_data,
	input  wire logic             out_ready,
	// Fill level
	output logic [CW-1:0]         level
);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wp_q;
	logic [AW-1:0]    wp_d;
	logic [AW-1:0]    rp_q;
	logic [AW-1:0]    rp_d;
	logic [CW-1:0]    cnt_q;
	logic [CW-1:0]    cnt_d;
	logic             push;
	logic             pop;

	// Pointer wrap that also works for depths that are not a power of two
	function automatic logic [AW-1:0] nxt(input logic [AW-1:0] p);
		if (p == AW'(DEPTH - 1))
			return '0;
		return p + AW'(1);
	endfunction : nxt

	assign in_ready  = (cnt_q != CW'(DEPTH));
	assign out_valid = (cnt_q != '0);
	assign out_data  = mem[rp_q];
	assign level     = cnt_q;

	always_comb
	begin
		push  = in_valid & in_ready;
		pop   = out_valid & out_ready;
		wp_d  = push ? nxt(wp_q) : wp_q;
		rp_d  = pop ? nxt(rp_q) : rp_q;
		cnt_d = cnt_q + CW'(push) - CW'(pop);
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			wp_q  <= '0;
			rp_q  <= '0;
			cnt_q <= '0;
		end
		else
		begin
			wp_q  <= wp_d;
			rp_q  <= rp_d;
			cnt_q <= cnt_d;
		end
	end

	// Storage has no reset; empty flag guards stale words
	always_ff @(posedge clk)
	begin
		if (push)
			mem[wp_q] <= in_data;
	end
endmodule : dlo_fifo

// Contract
// - Even bits of each sample launch with the forwarded clock rising edge.
// - Odd bits of each sample launch with the forwarded clock falling edge.
// - Two bits per pair per cycle; seven data pairs plus one clock pair.
// - Drive current select: 3.5 mA default, else 2.5, 4.5 or 1.75 mA.
// - Current double setting doubles drive for data and clock buffers.
// - Three termination resistors, any combination, eight settings from open.
// - Data pair and clock pair termination fields are separate.
// - Output coding two's complement or offset binary, by pin or register bit.
// - Differential DDR or parallel single-ended output, by register bit or strap.
module dlo_ddr_out
#(
	parameter int SAMPLE_W   = 12,
	parameter int PAIRS      = 7,
	parameter int FIFO_DEPTH = 16,
	localparam int LW        = $clog2(FIFO_DEPTH + 1)
)
(
	// Clock and reset
	input  wire logic                CLK_SYS,
	input  wire logic                RESET,
	// Avalon-MM register slave
	input  wire logic [1:0]          AVS_ADDRESS,
	input  wire logic                AVS_READ,
	input  wire logic                AVS_WRITE,
	input  wire logic [3:0]          AVS_BYTEENABLE,
	input  wire logic [31:0]         AVS_WRITEDATA,
	output logic [31:0]              AVS_READDATA,
	output logic                     AVS_WAITREQUEST,
	// Conversion results, two's complement
	input  wire logic                SMP_VALID,
	input  wire logic [SAMPLE_W-1:0] SMP_DATA,
	output logic                     SMP_READY,
	// Pins from outside the clock domain
	input  wire logic                SAMPLE_CLK,
	input  wire logic                FORMAT_STRAP_PIN,
	input  wire logic                STD_STRAP_PIN,
	// Differential DDR outputs
	output logic [PAIRS-1:0]         DATA_PAIR_POS,
	output logic [PAIRS-1:0]         DATA_PAIR_NEG,
	output logic                     FORWARDED_CLOCK_POS,
	output logic                     FORWARDED_CLOCK_NEG,
	output logic                     LVDS_OE,
	// Parallel single-ended outputs
	output logic [SAMPLE_W-1:0]      CMOS_DATA,
	output logic                     CMOS_OE,
	// Buffer settings
	output logic [1:0]               DRIVE_SEL,
	output logic                     CURRENT_DOUBLE,
	output logic [2:0]               DATA_TERM,
	output logic [2:0]               CLOCK_PAIR_TERMINATION
);
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (RESET);

	// Bit 0 sample clock, bit 1 format strap, bit 2 standard strap
	logic [2:0]          s1_q;
	logic [2:0]          s2_q;
	logic [2:0]          s3_q;
	logic [2:0]          st_q;
	logic [2:0]          st_d;
	logic                rise;
	logic                fall;
	logic                ack_q;
	logic                ack_d;
	logic [31:0]         rdata_q;
	logic [31:0]         rdata_d;
	logic [1:0]          drv_q;
	logic [1:0]          drv_d;
	logic                dbl_q;
	logic                dbl_d;
	logic                fmt_q;
	logic                fmt_d;
	logic                std_q;
	logic                std_d;
	logic [2:0]          dterm_q;
	logic [2:0]          dterm_d;
	logic [2:0]          cterm_q;
	logic [2:0]          cterm_d;
	logic                wr_ctrl;
	logic                ob_eff;
	logic                cmos_eff;
	logic [SAMPLE_W-1:0] word_q;
	logic [SAMPLE_W-1:0] word_d;
	logic [PAIRS-1:0]    pair_q;
	logic [PAIRS-1:0]    pair_d;
	logic                fwd_q;
	logic                fwd_d;
	logic [SAMPLE_W-1:0] cdat_q;
	logic [SAMPLE_W-1:0] cdat_d;
	logic                loe_q;
	logic                loe_d;
	logic                coe_q;
	logic                coe_d;
	logic                f_valid;
	logic [SAMPLE_W-1:0] f_data;
	logic [LW-1:0]       f_level;

	// Picks bit 2i+ph for pair i; bits past the sample width send zero
	function automatic logic [PAIRS-1:0] lane_bits(input logic [SAMPLE_W-1:0] w,
		input int ph);
		logic [PAIRS-1:0] r;
		r = '0;
		for (int i = 0; i < PAIRS; i++)
			if (2 * i + ph < SAMPLE_W)
				r[i] = w[2 * i + ph];
		return r;
	endfunction : lane_bits

	// Offset binary only flips the top bit of the two's complement code
	function automatic logic [SAMPLE_W-1:0] coded(input logic [SAMPLE_W-1:0] w,
		input logic ob);
		return {w[SAMPLE_W-1] ^ ob, w[SAMPLE_W-2:0]};
	endfunction : coded

	dlo_fifo #(
		.WIDTH (SAMPLE_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk       (CLK_SYS),
		.rst       (RESET),
		.in_valid  (SMP_VALID),
		.in_data   (SMP_DATA),
		.in_ready  (SMP_READY),
		.out_valid (f_valid),
		.out_data  (f_data),
		.out_ready (rise),
		.level     (f_level)
	);

	// Pin synchronisers; a change counts once stages two and three agree
	always_comb
	begin
		st_d = (s2_q & s3_q) | (st_q & (s2_q ^ s3_q));
		rise = ~st_q[0] & s2_q[0] & s3_q[0];
		fall = st_q[0] & ~s2_q[0] & ~s3_q[0];
	end

	always_ff @(posedge CLK_SYS or posedge RESET)
	begin
		if (RESET)
		begin
			s1_q <= 3'h0;
			s2_q <= 3'h0;
			s3_q <= 3'h0;
			st_q <= 3'h0;
		end
		else
		begin
			s1_q <= {STD_STRAP_PIN, FORMAT_STRAP_PIN, SAMPLE_CLK};
			s2_q <= s1_q;
			s3_q <= s2_q;
			st_q <= st_d;
		end
	end

	// Either the strap or the register bit selects the mode
	assign ob_eff   = fmt_q | st_q[1];
	assign cmos_eff = std_q | st_q[2];

	// Register slave: every access waits exactly one cycle
	always_comb
	begin
		ack_d   = (AVS_READ | AVS_WRITE) & ~ack_q;
		wr_ctrl = AVS_WRITE & ack_q & (AVS_ADDRESS == dlo_pkg::ADDR_CTRL);
		drv_d   = drv_q;
		dbl_d   = dbl_q;
		fmt_d   = fmt_q;
		std_d   = std_q;
		dterm_d = dterm_q;
		cterm_d = cterm_q;
		rdata_d = rdata_q;
		if (wr_ctrl && AVS_BYTEENABLE[0])
		begin
			drv_d = AVS_WRITEDATA[dlo_pkg::CTRL_DRV_LSB +: 2];
			dbl_d = AVS_WRITEDATA[dlo_pkg::CTRL_DBL_BIT];
			fmt_d = AVS_WRITEDATA[dlo_pkg::CTRL_FMT_BIT];
			std_d = AVS_WRITEDATA[dlo_pkg::CTRL_STD_BIT];
		end
		if (wr_ctrl && AVS_BYTEENABLE[1])
		begin
			dterm_d = AVS_WRITEDATA[dlo_pkg::CTRL_DTERM_LSB +: 3];
			cterm_d = AVS_WRITEDATA[dlo_pkg::CTRL_CTERM_LSB +: 3];
		end
		if (AVS_READ && !ack_q)
		begin
			rdata_d = 32'h0000_0000;
			unique case (AVS_ADDRESS)
				dlo_pkg::ADDR_CTRL:
				begin
					rdata_d[dlo_pkg::CTRL_DRV_LSB +: 2]   = drv_q;
					rdata_d[dlo_pkg::CTRL_DBL_BIT]        = dbl_q;
					rdata_d[dlo_pkg::CTRL_FMT_BIT]        = fmt_q;
					rdata_d[dlo_pkg::CTRL_STD_BIT]        = std_q;
					rdata_d[dlo_pkg::CTRL_DTERM_LSB +: 3] = dterm_q;
					rdata_d[dlo_pkg::CTRL_CTERM_LSB +: 3] = cterm_q;
				end
				dlo_pkg::ADDR_STATUS:
				begin
					rdata_d[dlo_pkg::STAT_EMPTY_BIT]     = ~f_valid;
					rdata_d[dlo_pkg::STAT_FULL_BIT]      = ~SMP_READY;
					rdata_d[dlo_pkg::STAT_FMT_BIT]       = ob_eff;
					rdata_d[dlo_pkg::STAT_STD_BIT]       = cmos_eff;
					rdata_d[dlo_pkg::STAT_LVL_LSB +: LW] = f_level;
				end
				dlo_pkg::ADDR_LAST:
					rdata_d[SAMPLE_W-1:0] = word_q;
				default:
					rdata_d = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge CLK_SYS or posedge RESET)
	begin
		if (RESET)
		begin
			ack_q   <= 1'b0;
			rdata_q <= 32'h0000_0000;
			drv_q   <= dlo_pkg::DRV_RST;
			dbl_q   <= dlo_pkg::DBL_RST;
			fmt_q   <= dlo_pkg::FMT_RST;
			std_q   <= dlo_pkg::STD_RST;
			dterm_q <= dlo_pkg::DTERM_RST;
			cterm_q <= dlo_pkg::CTERM_RST;
		end
		else
		begin
			ack_q   <= ack_d;
			rdata_q <= rdata_d;
			drv_q   <= drv_d;
			dbl_q   <= dbl_d;
			fmt_q   <= fmt_d;
			std_q   <= std_d;
			dterm_q <= dterm_d;
			cterm_q <= cterm_d;
		end
	end

	// Launch: an empty FIFO repeats the last sample rather than stall the link
	always_comb
	begin
		word_d = word_q;
		pair_d = pair_q;
		fwd_d  = fwd_q;
		cdat_d = cdat_q;
		loe_d  = ~cmos_eff;
		coe_d  = cmos_eff;
		if (rise)
		begin
			if (f_valid)
				word_d = coded(f_data, ob_eff);
			pair_d = lane_bits(word_d, 0);
			fwd_d  = 1'b1;
			cdat_d = word_d;
		end
		else if (fall)
		begin
			pair_d = lane_bits(word_q, 1);
			fwd_d  = 1'b0;
		end
	end

	always_ff @(posedge CLK_SYS or posedge RESET)
	begin
		if (RESET)
		begin
			word_q <= '0;
			pair_q <= '0;
			fwd_q  <= 1'b0;
			cdat_q <= '0;
			loe_q  <= 1'b0;
			coe_q  <= 1'b0;
		end
		else
		begin
			word_q <= word_d;
			pair_q <= pair_d;
			fwd_q  <= fwd_d;
			cdat_q <= cdat_d;
			loe_q  <= loe_d;
			coe_q  <= coe_d;
		end
	end

	assign AVS_WAITREQUEST        = (AVS_READ | AVS_WRITE) & ~ack_q;
	assign AVS_READDATA           = rdata_q;
	assign DATA_PAIR_POS          = pair_q;
	assign DATA_PAIR_NEG          = ~pair_q;
	assign FORWARDED_CLOCK_POS    = fwd_q;
	assign FORWARDED_CLOCK_NEG    = ~fwd_q;
	assign LVDS_OE                = loe_q;
	assign CMOS_DATA              = cdat_q;
	assign CMOS_OE                = coe_q;
	assign DRIVE_SEL              = drv_q;
	assign CURRENT_DOUBLE         = dbl_q;
	assign DATA_TERM              = dterm_q;
	assign CLOCK_PAIR_TERMINATION = cterm_q;

	a_bus_answer: assert property ((AVS_READ | AVS_WRITE) && !ack_q |=> !AVS_WAITREQUEST)
		else $error("Bus answer late");
	a_even_launch: assert property (rise |=> FORWARDED_CLOCK_POS
		&& DATA_PAIR_POS == lane_bits(word_q, 0))
		else $error("Even bits not on rising clock");
	a_odd_launch: assert property (fall |=> !FORWARDED_CLOCK_POS
		&& DATA_PAIR_POS == lane_bits($past(word_q), 1))
		else $error("Odd bits not on falling clock");
	a_pair_diff: assert property (DATA_PAIR_NEG == ~DATA_PAIR_POS
		&& FORWARDED_CLOCK_NEG != FORWARDED_CLOCK_POS)
		else $error("Pair legs not complementary");
	a_drive_write: assert property (wr_ctrl && AVS_BYTEENABLE[0] |=>
		DRIVE_SEL == $past(AVS_WRITEDATA[dlo_pkg::CTRL_DRV_LSB +: 2]))
		else $error("Drive select not written");
	a_double_write: assert property (wr_ctrl && AVS_BYTEENABLE[0] |=>
		CURRENT_DOUBLE == $past(AVS_WRITEDATA[dlo_pkg::CTRL_DBL_BIT]))
		else $error("Current double not written");
	a_term_hold: assert property (!wr_ctrl |=> $stable(DATA_TERM)
		&& $stable(CLOCK_PAIR_TERMINATION))
		else $error("Termination changed without write");
	a_term_split: assert property (wr_ctrl && AVS_BYTEENABLE[1] |=>
		DATA_TERM == $past(AVS_WRITEDATA[dlo_pkg::CTRL_DTERM_LSB +: 3])
		&& CLOCK_PAIR_TERMINATION == $past(AVS_WRITEDATA[dlo_pkg::CTRL_CTERM_LSB +: 3]))
		else $error("Termination fields mixed");
	a_format_msb: assert property (rise && f_valid |=>
		word_q == {$past(f_data[SAMPLE_W-1]) ^ $past(ob_eff), $past(f_data[SAMPLE_W-2:0])})
		else $error("Coding wrong");
	// Skips the edge on which reset lets go, where the enables still hold reset values
	a_std_select: assert property (!RESET |=> LVDS_OE == !$past(cmos_eff)
		&& CMOS_OE == $past(cmos_eff))
		else $error("Output standard wrong");

	c_sample_pair: cover property (rise ##[1:40] fall);
	c_fifo_full: cover property (!SMP_READY);
	c_offset_bin: cover property (rise && f_valid && ob_eff);
	c_cmos_mode: cover property (CMOS_OE ##1 rise);
endmodule : dlo_ddr_out

// [hdl/dlo_pkg.sv]
// Constants for the DDR differential sample output stage
package dlo_pkg;
	// Register word addresses (byte address = 4 x word address)
	localparam logic [1:0] ADDR_CTRL   = 2'h0;
	localparam logic [1:0] ADDR_STATUS = 2'h1;
	localparam logic [1:0] ADDR_LAST   = 2'h2;
	// Control word field positions
	localparam int CTRL_DRV_LSB   = 0;
	localparam int CTRL_DBL_BIT   = 2;
	localparam int CTRL_FMT_BIT   = 3;
	localparam int CTRL_STD_BIT   = 4;
	localparam int CTRL_DTERM_LSB = 8;
	localparam int CTRL_CTERM_LSB = 12;
	// Status word field positions
	localparam int STAT_EMPTY_BIT = 0;
	localparam int STAT_FULL_BIT  = 1;
	localparam int STAT_FMT_BIT   = 2;
	localparam int STAT_STD_BIT   = 3;
	localparam int STAT_LVL_LSB   = 8;
	// Drive current codes
	localparam logic [1:0] DRV_3P5MA  = 2'h0;
	localparam logic [1:0] DRV_2P5MA  = 2'h1;
	localparam logic [1:0] DRV_4P5MA  = 2'h2;
	localparam logic [1:0] DRV_1P75MA = 2'h3;
	// Termination bits: 0 = 300 ohm, 1 = 185 ohm, 2 = 150 ohm, in parallel
	localparam logic [2:0] TERM_OPEN  = 3'h0;
	// Reset values
	localparam logic [1:0] DRV_RST    = DRV_3P5MA;
	localparam logic       DBL_RST    = 1'b0;
	localparam logic       FMT_RST    = 1'b0;
	localparam logic       STD_RST    = 1'b0;
	localparam logic [2:0] DTERM_RST  = TERM_OPEN;
	localparam logic [2:0] CTERM_RST  = TERM_OPEN;
endpackage : dlo_pkg

// [tb/dlo_ddr_out_tb.sv]
// Self-checking bench for the DDR differential sample output stage
`timescale 1ns/1ns
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin error_cnt++; \
	$display("[FAIL] %0t got %0h exp %0h", $time, (a), (b)); end end

module dlo_ddr_out_tb;
	typedef struct packed {logic [15:0] ctrl; logic [1:0] drv; logic dbl;
		logic [2:0] dt; logic [2:0] ct;} dlo_row_s;
	logic        CLK_SYS = 1'b0;
	logic        RESET = 1'b1;
	logic [1:0]  AVS_ADDRESS = 2'h0;
	logic        AVS_READ = 1'b0;
	logic        AVS_WRITE = 1'b0;
	logic [3:0]  AVS_BYTEENABLE = 4'hF;
	logic [31:0] AVS_WRITEDATA = 32'h0;
	logic        SMP_VALID = 1'b0;
	logic [11:0] SMP_DATA = 12'h0;
	logic        SAMPLE_CLK = 1'b0;
	logic        FORMAT_STRAP_PIN = 1'b0;
	logic        STD_STRAP_PIN = 1'b0;
	logic [31:0] AVS_READDATA;
	logic        AVS_WAITREQUEST;
	logic        SMP_READY;
	logic [6:0]  DATA_PAIR_POS;
	logic [6:0]  DATA_PAIR_NEG;
	logic        FORWARDED_CLOCK_POS;
	logic        FORWARDED_CLOCK_NEG;
	logic        LVDS_OE;
	logic [11:0] CMOS_DATA;
	logic        CMOS_OE;
	logic [1:0]  DRIVE_SEL;
	logic        CURRENT_DOUBLE;
	logic [2:0]  DATA_TERM;
	logic [2:0]  CLOCK_PAIR_TERMINATION;
	logic        rx_v;
	logic [11:0] rx_w;
	logic [31:0] rd;
	logic        run = 1'b0;
	logic [11:0] raw [16];
	logic [11:0] rxq [$];
	int          error_cnt = 0;
	int          check_count = 0;
	int          rises = 0;
	int          ph = 0;
	dlo_row_s    rows [5] = '{'{16'h7001, 2'h1, 1'h0, 3'h0, 3'h7},
		'{16'h0706, 2'h2, 1'h1, 3'h7, 3'h0}, '{16'h3507, 2'h3, 1'h1, 3'h5, 3'h3},
		'{16'h1200, 2'h0, 1'h0, 3'h2, 3'h1}, '{16'h4604, 2'h0, 1'h1, 3'h6, 3'h4}};

	dlo_ddr_out u_dlo_ddr_out (.CLK_SYS(CLK_SYS), .RESET(RESET), .AVS_ADDRESS(AVS_ADDRESS),
		.AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_BYTEENABLE(AVS_BYTEENABLE),
		.AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA),
		.AVS_WAITREQUEST(AVS_WAITREQUEST), .SMP_VALID(SMP_VALID), .SMP_DATA(SMP_DATA),
		.SMP_READY(SMP_READY), .SAMPLE_CLK(SAMPLE_CLK), .FORMAT_STRAP_PIN(FORMAT_STRAP_PIN),
		.STD_STRAP_PIN(STD_STRAP_PIN), .DATA_PAIR_POS(DATA_PAIR_POS),
		.DATA_PAIR_NEG(DATA_PAIR_NEG), .FORWARDED_CLOCK_POS(FORWARDED_CLOCK_POS),
		.FORWARDED_CLOCK_NEG(FORWARDED_CLOCK_NEG), .LVDS_OE(LVDS_OE), .CMOS_DATA(CMOS_DATA),
		.CMOS_OE(CMOS_OE), .DRIVE_SEL(DRIVE_SEL), .CURRENT_DOUBLE(CURRENT_DOUBLE),
		.DATA_TERM(DATA_TERM), .CLOCK_PAIR_TERMINATION(CLOCK_PAIR_TERMINATION));
	dlo_rx_model u_dlo_rx_model (.clk(CLK_SYS), .rst(RESET), .pair_pos(DATA_PAIR_POS),
		.clk_pos(FORWARDED_CLOCK_POS), .word_valid(rx_v), .word(rx_w));

	always #4 CLK_SYS = ~CLK_SYS;
	// Sample clock of 160 ns; it only stops in its low phase, so the far side stalls cleanly
	always @(posedge CLK_SYS)
	begin
		ph <= (ph == 9) ? 0 : ph + 1;
		if (ph == 9 && SAMPLE_CLK)
			SAMPLE_CLK <= 1'b0;
		else if (ph == 9 && run)
		begin
			SAMPLE_CLK <= 1'b1;
			rises      <= rises + 1;
		end
	end
	always @(posedge CLK_SYS)
		if (rx_v === 1'b1)
			rxq.push_back(rx_w);

	task end_sim;
		$display("errors %0d checks %0d", error_cnt, check_count);
		if (error_cnt == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : end_sim

	// Answers are sampled at the rising edge; only the watchdog ends a wait
	task bus(input logic wr, input logic [1:0] a, input logic [3:0] be, input logic [31:0] wd);
		@(posedge CLK_SYS);
		AVS_ADDRESS    <= a;
		AVS_WRITE      <= wr;
		AVS_READ       <= !wr;
		AVS_BYTEENABLE <= be;
		AVS_WRITEDATA  <= wd;
		do
			@(posedge CLK_SYS);
		while (AVS_WAITREQUEST !== 1'b0);
		rd = AVS_READDATA;
		AVS_WRITE <= 1'b0;
		AVS_READ  <= 1'b0;
	endtask : bus

	task push(input logic [11:0] d);
		@(posedge CLK_SYS);
		SMP_VALID <= 1'b1;
		SMP_DATA  <= d;
		do
			@(posedge CLK_SYS);
		while (SMP_READY !== 1'b1);
		SMP_VALID <= 1'b0;
	endtask : push

	task run_to(input int k);
		run <= 1'b1;
		for (int t = 0; t < 4000 && rises < k; t++)
			@(posedge CLK_SYS);
		run <= 1'b0;
		repeat (40) @(posedge CLK_SYS);
	endtask : run_to

	initial
	begin
		repeat (12) @(posedge CLK_SYS);
		RESET <= 1'b0;
		repeat (2) @(negedge CLK_SYS);
		`CHK(LVDS_OE, 1'b1)
		`CHK(DRIVE_SEL, dlo_pkg::DRV_RST)
		`CHK(FORWARDED_CLOCK_NEG, 1'b1)
		bus(1'b0, dlo_pkg::ADDR_STATUS, 4'hF, 32'h0);
		`CHK(rd, 32'h00000001)
		foreach (rows[i])
		begin
			bus(1'b1, dlo_pkg::ADDR_CTRL, 4'hF, {16'h0000, rows[i].ctrl});
			@(negedge CLK_SYS);
			`CHK(DRIVE_SEL, rows[i].drv)
			`CHK(CURRENT_DOUBLE, rows[i].dbl)
			`CHK(DATA_TERM, rows[i].dt)
			`CHK(CLOCK_PAIR_TERMINATION, rows[i].ct)
			bus(1'b0, dlo_pkg::ADDR_CTRL, 4'hF, 32'h0);
			`CHK(rd[15:0], rows[i].ctrl)
		end
		// Lane 1 left out, so the termination fields must survive
		bus(1'b1, dlo_pkg::ADDR_CTRL, 4'h1, 32'h0);
		@(negedge CLK_SYS);
		`CHK(CURRENT_DOUBLE, 1'b0)
		`CHK(DATA_TERM, 3'h6)
		bus(1'b1, 2'h3, 4'hF, 32'hFFFFFFFF);
		bus(1'b0, 2'h3, 4'hF, 32'h0);
		`CHK(rd, 32'h00000000)
		for (int i = 0; i < 16; i++)
		begin
			raw[i] = 12'(12'h801 + 12'h125 * i);
			push(raw[i]);
		end
		@(negedge CLK_SYS);
		`CHK(SMP_READY, 1'b0)
		bus(1'b0, dlo_pkg::ADDR_STATUS, 4'hF, 32'h0);
		`CHK(rd, 32'h00001002)
		run_to(8);
		bus(1'b1, dlo_pkg::ADDR_CTRL, 4'hF, 32'h00000008);
		run_to(17);
		`CHK(rxq.size(), 16)
		foreach (raw[i])
			`CHK(rxq[i], raw[i] ^ ((i >= 8) ? 12'h800 : 12'h000))
		`CHK(DATA_PAIR_NEG, ~DATA_PAIR_POS)
		`CHK(CMOS_DATA, raw[15] ^ 12'h800)
		bus(1'b0, dlo_pkg::ADDR_LAST, 4'hF, 32'h0);
		`CHK(rd, {20'h00000, raw[15] ^ 12'h800})
		bus(1'b1, dlo_pkg::ADDR_CTRL, 4'hF, 32'h00000018);
		run_to(18);
		`CHK(CMOS_OE, 1'b1)
		`CHK(LVDS_OE, 1'b0)
		bus(1'b1, dlo_pkg::ADDR_CTRL, 4'hF, 32'h0);
		STD_STRAP_PIN    <= 1'b1;
		FORMAT_STRAP_PIN <= 1'b1;
		run_to(19);
		bus(1'b0, dlo_pkg::ADDR_STATUS, 4'hF, 32'h0);
		`CHK(rd[3:2], 2'h3)
		`CHK(CMOS_OE, 1'b1)
		end_sim;
	end

	// About eighty times the expected run length
	initial
	begin
		#400000;
		error_cnt++;
		end_sim;
	end
endmodule : dlo_ddr_out_tb

// [tb/dlo_rx_model.sv]
// Receiver model that rebuilds samples from both forwarded clock phases
`timescale 1ns/1ns

module dlo_rx_model
(
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// Link from the output stage
	input  wire logic [6:0] pair_pos,
	input  wire logic       clk_pos,
	// Rebuilt samples
	output logic            word_valid,
	output logic [11:0]     word
);
	logic       pos_q;
	logic       have_q;
	logic [6:0] prev_q;
	logic [6:0] even_q;

	// Phases are told apart by the clock pair itself, never by cycle counts
	always @(posedge clk)
	begin
		word_valid <= 1'b0;
		pos_q      <= clk_pos;
		prev_q     <= pair_pos;
		if (rst)
			have_q <= 1'b0;
		else if (pos_q && !clk_pos)
		begin
			even_q <= prev_q;
			have_q <= 1'b1;
		end
		else if (!pos_q && clk_pos && have_q)
		begin
			word_valid <= 1'b1;
			for (int i = 0; i < 6; i++)
			begin
				word[2*i]   <= even_q[i];
				word[2*i+1] <= prev_q[i];
			end
		end
	end
endmodule : dlo_rx_model
